// ---- src/limiter_map.svh ----
// Register map, reset values and arithmetic constants of the output limiter.
// Assumes inclusion by bare name from the package and the design files.
`ifndef LIMITER_MAP_SVH
`define LIMITER_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_P1L_CEIL   14'h0412
`define IDX_P1R_CEIL   14'h0416
`define IDX_P2L_CEIL   14'h041A
`define IDX_P1L_VOL    14'h0500
`define IDX_P1R_VOL    14'h0501
`define IDX_P2L_VOL    14'h0502
`define IDX_CLIP_STAT  14'h0510

// Reset values of the code fields.
`define CEIL_RESET     8'h81
`define VOL_RESET      8'h80

// Code landmarks.
`define CODE_0DB       8'h80
`define CEIL_CODE_MIN  8'h74
`define CEIL_CODE_MAX  8'h8C
`define VOL_RESERVED   8'hEC

// Gain arithmetic: twelve half-decibel steps make one doubling.
`define GAIN_BIAS      9'h004
`define GAIN_STEPS     9'h00C
`define GAIN_FRAC      7'h1A
`define FULL_SCALE     24'h7FFFFF
`define OUT_MAX        26'h1FFFFFF
`define OUT_MIN        26'h2000000

// Channel codes and buffer fill level.
`define CHAN_P1L       2'h0
`define CHAN_P1R       2'h1
`define CHAN_P2L       2'h2
`define BUF_FULL       2'h2
`define BUF_EMPTY      2'h0

`endif

// ---- src/limiter_pkg.sv ----
// Types shared by the limiter top and its output buffer.
// Assumes limiter_map.svh is on the include path.
`include "limiter_map.svh"

package limiter_pkg;

  typedef logic [7:0] code_t;

  // Sample arriving from the sample source, ahead of the volume stage, with its channel.
  typedef struct packed {
    logic [1:0]         chan;
    logic signed [23:0] data;
  } sample_t;

  // Limited sample handed to the output converters; 26 bits give headroom.
  typedef struct packed {
    logic [1:0]         chan;
    logic               clipped;
    logic signed [25:0] data;
  } dac_word_t;

endpackage

// ---- src/pair_buffer.sv ----
// Two-entry buffer between the limiter and the output converters.
// Assumes both sides run on the same clock and use valid/ready handshakes.
`timescale 1ns/1ns
`include "limiter_map.svh"

module pair_buffer (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire limiter_pkg::dac_word_t in_word,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output limiter_pkg::dac_word_t     out_word
);
  import limiter_pkg::*;

  dac_word_t  slot_reg [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic       push;
  logic       pop;

  // Full and empty follow the fill count; the head slot is read directly.
  assign in_ready   = (count_reg != `BUF_FULL);
  assign out_valid  = (count_reg != `BUF_EMPTY);
  assign out_word   = slot_reg[rd_ptr_reg];
  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

  // Pointers and count move on each accepted word.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= `BUF_EMPTY;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg  <= count_next;
    end
  end

  // Storage needs no reset; out_valid masks stale slots.
  always_ff @(posedge clk) begin
    if (push) begin
      slot_reg[wr_ptr_reg] <= in_word;
    end
  end

endmodule

// ---- src/output_limiter.sv ----
// Output path digital volume and clipping limiter with an APB register port.
// Assumes a same-clock sample source and converter sink with valid/ready.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "limiter_map.svh"

module output_path_digital_limiter (
  input  wire logic                   REF_CLK,
  input  wire logic                   RST_N,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [15:0]            PADDR,
  input  wire logic [31:0]            PWDATA,
  input  wire logic [3:0]             PSTRB,
  output logic [31:0]                 PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire limiter_pkg::sample_t   SAMPLE_IN,
  input  wire logic                   SAMPLE_IN_VALID,
  output logic                        SAMPLE_IN_READY,
  output limiter_pkg::dac_word_t      DAC_OUT,
  output logic                        DAC_OUT_VALID,
  input  wire logic                   DAC_OUT_READY
);
  import limiter_pkg::*;

  // One ratio per half-decibel step within an octave, unsigned Q1.15.
  function automatic logic [16:0] step_ratio(input logic [3:0] r);
    logic [16:0] t;
    t = 17'h08000;
    case (r)
      4'h1:    t = 17'h0879C;
      4'h2:    t = 17'h08FAD;
      4'h3:    t = 17'h09838;
      4'h4:    t = 17'h0A145;
      4'h5:    t = 17'h0AADC;
      4'h6:    t = 17'h0B505;
      4'h7:    t = 17'h0BFC9;
      4'h8:    t = 17'h0CB30;
      4'h9:    t = 17'h0D745;
      4'hA:    t = 17'h0E412;
      4'hB:    t = 17'h0F1A2;
      default: t = 17'h08000;
    endcase
    return t;
  endfunction

  // Scales a sample by the gain of a code where 80h is unity, saturating.
  function automatic logic signed [25:0] apply_gain(
      input logic signed [23:0] s, input code_t code);
    logic [8:0]         n;
    logic [4:0]         e;
    logic [3:0]         r;
    logic signed [41:0] p;
    logic signed [63:0] w;
    logic signed [25:0] y;
    n = {1'b0, code} + `GAIN_BIAS;
    e = 5'(n / `GAIN_STEPS);
    r = 4'(n % `GAIN_STEPS);
    p = 42'(s) * 42'(signed'({1'b0, step_ratio(r)}));
    w = (64'(p) <<< e) >>> `GAIN_FRAC;
    if (w > 64'(signed'(`OUT_MAX))) begin
      y = signed'(`OUT_MAX);
    end else if (w < 64'(signed'(`OUT_MIN))) begin
      y = signed'(`OUT_MIN);
    end else begin
      y = 26'(w);
    end
    return y;
  endfunction

  code_t              ceil_code_reg [3];
  code_t              vol_code_reg  [3];
  logic [2:0]         clip_flag_reg;
  logic [2:0]         clip_flag_next;
  logic [31:0]        prdata_reg;
  logic               pslverr_reg;
  logic [13:0]        idx;
  logic               apb_setup;
  logic               apb_write;
  logic [2:0]         hit_ceil;
  logic [2:0]         hit_vol;
  logic               hit_stat;
  logic               addr_ok;
  logic [31:0]        rd_value;
  logic [2:0]         wr_ceil;
  logic [2:0]         wr_vol;
  logic [2:0]         clr_mask;
  logic [2:0]         set_mask;
  logic signed [25:0] ceil_level [3];
  logic [1:0]         in_chan;
  logic               chan_ok;
  logic               in_fire;
  logic               push_valid;
  logic               buf_in_ready;
  logic signed [25:0] gained;
  logic signed [25:0] level;
  logic signed [25:0] limited;
  logic               over_pos;
  logic               over_neg;
  dac_word_t          push_word;

  // Bus decode: the word index selects a register, misalignment is an error.
  assign idx       = PADDR[15:2];
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_write = PSEL & PENABLE & PWRITE & ~pslverr_reg;
  assign hit_ceil  = {idx == `IDX_P2L_CEIL, idx == `IDX_P1R_CEIL,
                      idx == `IDX_P1L_CEIL};
  assign hit_vol   = {idx == `IDX_P2L_VOL, idx == `IDX_P1R_VOL,
                      idx == `IDX_P1L_VOL};
  assign hit_stat  = (idx == `IDX_CLIP_STAT);
  assign addr_ok   = (PADDR[1:0] == 2'h0) &
                     ((|hit_ceil) | (|hit_vol) | hit_stat);

  // Read selection; unused bits read as zero.
  assign rd_value =
      hit_ceil[0] ? {24'h000000, ceil_code_reg[0]} :
      hit_ceil[1] ? {24'h000000, ceil_code_reg[1]} :
      hit_ceil[2] ? {24'h000000, ceil_code_reg[2]} :
      hit_vol[0]  ? {24'h000000, vol_code_reg[0]}  :
      hit_vol[1]  ? {24'h000000, vol_code_reg[1]}  :
      hit_vol[2]  ? {24'h000000, vol_code_reg[2]}  :
      hit_stat    ? {29'h00000000, clip_flag_reg}  : 32'h00000000;

  // Write strobes: low byte lane only; status bits are write-one-to-clear.
  assign wr_ceil  = hit_ceil & {3{apb_write & PSTRB[0]}};
  assign wr_vol   = hit_vol & {3{apb_write & PSTRB[0]}};
  assign clr_mask = PWDATA[2:0] & {3{apb_write & PSTRB[0] & hit_stat}};
  assign set_mask = push_valid & over_pos | push_valid & over_neg
                    ? 3'(3'h1 << in_chan) : 3'h0;
  // A clip arriving with its clear keeps the flag set.
  assign clip_flag_next = (clip_flag_reg & ~clr_mask) | set_mask;

  // Zero-wait slave; data and error are prepared in the setup cycle.
  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_reg;
  assign PSLVERR = pslverr_reg;

  // Captures read data and the error answer during setup.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg  <= rd_value;
      pslverr_reg <= ~addr_ok;
    end
  end

  // Code registers, each channel independent, with documented resets.
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < 3; i++) begin
      if (!RST_N) begin
        ceil_code_reg[i] <= `CEIL_RESET;
        vol_code_reg[i]  <= `VOL_RESET;
      end else begin
        if (wr_ceil[i]) ceil_code_reg[i] <= PWDATA[7:0];
        if (wr_vol[i])  vol_code_reg[i]  <= PWDATA[7:0];
      end
    end
  end

  // Sticky clip flags for software.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) clip_flag_reg <= 3'h0;
    else        clip_flag_reg <= clip_flag_next;
  end

  // Ceiling levels follow the codes directly, so a write counts at once.
  // Reserved codes fall out of the same formula and are not trapped.
  for (genvar g = 0; g < 3; g++) begin : g_ceil
    assign ceil_level[g] = apply_gain(signed'(`FULL_SCALE),
                                      ceil_code_reg[g]);
  end

  // Sample path: volume, then symmetric saturation, then the buffer.
  assign in_chan  = SAMPLE_IN.chan;
  assign chan_ok  = (in_chan != 2'h3);
  assign SAMPLE_IN_READY = buf_in_ready;
  assign in_fire  = SAMPLE_IN_VALID & buf_in_ready;
  assign push_valid = in_fire & chan_ok;
  assign gained   = (vol_code_reg[in_chan] >= `VOL_RESERVED) ? 26'sh0 :
                    apply_gain(SAMPLE_IN.data, vol_code_reg[in_chan]);
  assign level    = ceil_level[in_chan];
  assign over_pos = (gained > level);
  assign over_neg = (gained < -level);
  assign limited  = over_pos ? level : over_neg ? -level : gained;
  assign push_word = '{chan: in_chan, clipped: over_pos | over_neg,
                       data: limited};

  // Limited words wait here until the converters take them.
  pair_buffer u_buf (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .in_valid  (push_valid),
    .in_ready  (buf_in_ready),
    .in_word   (push_word),
    .out_valid (DAC_OUT_VALID),
    .out_ready (DAC_OUT_READY),
    .out_word  (DAC_OUT)
  );

  // Checks run on the bus clock and are off while reset is held.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_ceil_write(int i);
    apb_write && PSTRB[0] && hit_ceil[i];
  endsequence

  sequence s_refused_write;
    PSEL && PENABLE && PWRITE && (pslverr_reg || !PSTRB[0]);
  endsequence

  sequence s_stall_full;
    !SAMPLE_IN_READY && !DAC_OUT_READY;
  endsequence

  a_clip_to_ceiling: assert property (
    push_valid && gained > level |-> push_word.data == level)
    else $error("positive overshoot not clipped to ceiling");
  a_clip_negative: assert property (
    push_valid && gained < -level |-> push_word.data == -level)
    else $error("negative overshoot not clipped to ceiling");
  a_within_bound: assert property (
    push_valid |-> push_word.data <= level && push_word.data >= -level)
    else $error("pushed sample outside ceiling");
  a_code_reset: assert property (
    $rose(RST_N) |-> ceil_code_reg[0] == `CEIL_RESET
      && ceil_code_reg[2] == `CEIL_RESET)
    else $error("ceiling code not at reset value");
  a_ceil_scale: assert property (
    (ceil_code_reg[1] == `CODE_0DB |-> ceil_level[1] == 26'h07FFFFF)
    and (ceil_code_reg[1] == `CEIL_CODE_MAX |-> ceil_level[1] == 26'h0FFFFFE)
    and (ceil_code_reg[1] == `CEIL_CODE_MIN |-> ceil_level[1] == 26'h03FFFFF))
    else $error("ceiling level does not match code");
  a_write_separate: assert property (
    s_ceil_write(1)
    |=> ceil_code_reg[1] == $past(PWDATA[7:0])
      && $stable(ceil_code_reg[0]) && $stable(ceil_code_reg[2]))
    else $error("ceiling write wrong or leaked to another channel");
  a_next_sample: assert property (
    s_ceil_write(0) ##1 (push_valid && in_chan == `CHAN_P1L)
    |-> level == apply_gain(signed'(`FULL_SCALE), $past(PWDATA[7:0])))
    else $error("new ceiling not used by next sample");
  a_vol_reserved: assert property (
    push_valid && vol_code_reg[in_chan] >= `VOL_RESERVED
    |-> push_word.data == 26'sh0)
    else $error("reserved volume code did not mute");
  a_vol_unity: assert property (
    push_valid && vol_code_reg[in_chan] == `CODE_0DB && !over_pos && !over_neg
    |-> push_word.data == 26'(SAMPLE_IN.data))
    else $error("unity volume code altered the sample");
  a_hold_stalled: assert property (
    DAC_OUT_VALID && !DAC_OUT_READY |=> DAC_OUT_VALID && $stable(DAC_OUT))
    else $error("stalled converter word lost or changed");

  // Register side: reset values, read answers, writes and refused writes.
  a_vol_reset: assert property (
    $rose(RST_N) |-> ceil_code_reg[1] == `CEIL_RESET
      && vol_code_reg[0] == `VOL_RESET && vol_code_reg[2] == `VOL_RESET)
    else $error("code register not at reset value");
  a_read_ceiling: assert property (
    apb_setup && hit_ceil[0]
    |=> PRDATA == {24'h000000, $past(ceil_code_reg[0])})
    else $error("ceiling read answer wrong");
  a_write_path2: assert property (
    s_ceil_write(2)
    |=> ceil_code_reg[2] == $past(PWDATA[7:0]) && $stable(ceil_code_reg[0]))
    else $error("path two ceiling write wrong or leaked");
  a_vol_write: assert property (
    apb_write && PSTRB[0] && hit_vol[0]
    |=> vol_code_reg[0] == $past(PWDATA[7:0]))
    else $error("volume code write did not land");
  a_refused_keep: assert property (
    s_refused_write |=> $stable(ceil_code_reg[0])
      && $stable(ceil_code_reg[1]) && $stable(ceil_code_reg[2]))
    else $error("refused write changed a ceiling");

  // Sticky clip flags: a clip always sets, a clear alone empties.
  a_flag_set_wins: assert property (
    set_mask[0] |=> clip_flag_reg[0])
    else $error("clip event did not set its flag");
  a_flag_clear: assert property (
    clr_mask[0] && !set_mask[0] |=> !clip_flag_reg[0])
    else $error("cleared clip flag still set");

  // Sample path and buffer: pass-through, reset state and refusal when full.
  a_pass_unclipped: assert property (
    push_valid && !over_pos && !over_neg
    |-> push_word.data == gained && !push_word.clipped)
    else $error("unclipped sample altered or marked");
  a_reset_empty: assert property (
    $rose(RST_N) |-> !DAC_OUT_VALID && SAMPLE_IN_READY)
    else $error("buffer not empty after reset");
  a_full_hold: assert property (
    s_stall_full |=> !SAMPLE_IN_READY && $stable(DAC_OUT))
    else $error("full buffer accepted a word or changed");

endmodule

// ---- sim/dac_sink.sv ----
// Model of the output converters that take the limited samples.
// Assumes one clock; mode 0 always ready, 1 random stalls, 2 full stall.
`timescale 1ns/1ns

module dac_sink (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] mode,
  output logic            ready
);
  integer seed = 7;

  // Ready moves just after each edge, as a real converter would.
  always @(posedge clk) begin
    if (!rst_n) ready <= 1'b0;
    else if (mode == 2'h0) ready <= 1'b1;
    else if (mode == 2'h1) ready <= ($random(seed) % 2) != 0;
    else ready <= 1'b0;
  end
endmodule

// ---- sim/output_path_digital_limiter_test.sv ----
// Self-checking bench for the output path limiter and its APB registers.
// Assumes the design sources, limiter_map.svh and dac_sink are compiled.
`timescale 1ns/1ns
`include "limiter_map.svh"

module output_path_digital_limiter_test;
  import limiter_pkg::*;

  localparam logic [15:0] A_P1L = {`IDX_P1L_CEIL, 2'b00};
  localparam logic [15:0] A_P1R = {`IDX_P1R_CEIL, 2'b00};
  localparam logic [15:0] A_P2L = {`IDX_P2L_CEIL, 2'b00};
  localparam logic [15:0] V_P1L = {`IDX_P1L_VOL, 2'b00};
  localparam logic [15:0] V_P1R = {`IDX_P1R_VOL, 2'b00};
  localparam logic [15:0] A_STAT = {`IDX_CLIP_STAT, 2'b00};
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  sample_t     s_in = '0;
  logic        s_valid = 1'b0;
  logic        s_ready;
  dac_word_t   dac_out;
  logic        dac_valid;
  logic        dac_ready;
  logic [1:0]  sink_mode = 2'h0;
  dac_word_t   expq[$];
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  integer      seed = 21;

  output_path_digital_limiter u_output_path_digital_limiter (
    .REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SAMPLE_IN(s_in), .SAMPLE_IN_VALID(s_valid),
    .SAMPLE_IN_READY(s_ready), .DAC_OUT(dac_out),
    .DAC_OUT_VALID(dac_valid), .DAC_OUT_READY(dac_ready));

  dac_sink u_dac_sink (
    .clk(ref_clk), .rst_n(rst_n), .mode(sink_mode), .ready(dac_ready));

  // Free-running 125 MHz clock.
  always #4 ref_clk = ~ref_clk;

  task complete_run();
    $display("Comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // A hung handshake ends the run as a failure.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      chk(32'h0, 32'h1, "timeout");
      complete_run();
    end
  end

  // Each word accepted by the converters is matched to the oldest note.
  always @(posedge ref_clk) begin
    if (rst_n && dac_valid === 1'b1 && dac_ready === 1'b1)
      chk(32'(dac_out), expq.size() != 0 ? 32'(expq.pop_front()) :
          32'hFFFFFFFF, "dac word");
  end

  // One APB transfer; entered just after a rising edge.
  // An idle cycle follows the release, so a next setup never overlaps it.
  // Only the bench timeout ends a wait for the ready answer.
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
           input logic [3:0] s, input logic [31:0] er, input logic ee);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
        @(posedge ref_clk);
      end while (pready !== 1'b1);
      if (!wr) chk(prdata, er, "read data");
      chk({31'h0, pslverr}, {31'h0, ee}, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  // Offer one sample and note its expected limited word.
  task send(input logic [1:0] c, input logic [23:0] d,
            input logic signed [25:0] g, input logic signed [25:0] lim);
    int n;
    begin
      n = 0;
      if (c != 2'h3) expq.push_back(g > lim ? {c, 1'b1, lim} :
                                    g < -lim ? {c, 1'b1, -lim} : {c, 1'b0, g});
      s_in <= '{c, d};
      s_valid <= 1'b1;
      do begin
        @(posedge ref_clk);
        n++;
      end while (s_ready !== 1'b1 && n < 100);
    end
  endtask

  task idle_drain();
    int n;
    begin
      n = 0;
      s_valid <= 1'b0;
      @(posedge ref_clk);
      while (expq.size() != 0 && n < 200) begin
        @(posedge ref_clk);
        n++;
      end
    end
  endtask

  // Main sequence: reset, register checks, limiting, buffer, random.
  initial begin
    logic [31:0]       r;
    logic [1:0]        c;
    logic signed [25:0] g;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(0, A_P1L, 0, 4'hF, 32'h81, 0);
    apb(0, A_P1R, 0, 4'hF, 32'h81, 0);
    apb(0, A_P2L, 0, 4'hF, 32'h81, 0);
    apb(0, V_P1L, 0, 4'hF, 32'h80, 0);
    apb(0, A_STAT, 0, 4'hF, 32'h0, 0);
    // Separate ceilings per channel; only legal codes are used.
    apb(1, A_P1L, 32'h74, 4'hF, 0, 0);
    apb(1, A_P1R, 32'h80, 4'hF, 0, 0);
    apb(1, A_P2L, 32'h8C, 4'hF, 0, 0);
    send(2'h0, 24'h500000, 26'sh0500000, 26'sh03FFFFF);
    send(2'h0, 24'hB00000, -26'sh0500000, 26'sh03FFFFF);
    send(2'h0, 24'h3FFFFF, 26'sh03FFFFF, 26'sh03FFFFF);
    send(2'h1, 24'h500000, 26'sh0500000, 26'sh07FFFFF);
    send(2'h2, 24'hB00000, -26'sh0500000, 26'sh0FFFFFE);
    send(2'h3, 24'h7FFFFF, 26'sh0, 26'sh0);
    idle_drain();
    apb(0, A_STAT, 0, 4'hF, 32'h1, 0);
    apb(1, A_STAT, 32'h7, 4'hF, 0, 0);
    apb(0, A_STAT, 0, 4'hF, 32'h0, 0);
    // Refused and ignored accesses leave the ceiling untouched.
    apb(1, A_P1L, 32'h80, 4'h0, 0, 0);
    apb(0, 16'h0100, 0, 4'hF, 32'h0, 1);
    apb(1, A_P1L + 16'h1, 32'h80, 4'hF, 0, 1);
    apb(0, A_P1L, 0, 4'hF, 32'h74, 0);
    // Volume ahead of the limiter: +6 dB, then clipping at both polarities.
    apb(1, V_P1L, 32'h8C, 4'hF, 0, 0);
    apb(1, A_P1L, 32'h80, 4'hF, 0, 0);
    send(2'h0, 24'h7FFFFF, 26'sh0FFFFFE, 26'sh07FFFFF);
    send(2'h0, 24'hC00000, -26'sh0800000, 26'sh07FFFFF);
    idle_drain();
    // The sample is taken one cycle after the write and must see it.
    fork
      apb(1, A_P1L, 32'h8C, 4'hF, 0, 0);
      begin
        repeat (2) @(posedge ref_clk);
        send(2'h0, 24'h7FFFFF, 26'sh0FFFFFE, 26'sh0FFFFFE);
      end
    join
    idle_drain();
    apb(1, A_P1L, 32'h80, 4'hF, 0, 0);
    apb(1, A_P2L, 32'h80, 4'hF, 0, 0);
    apb(1, V_P1R, 32'hEC, 4'hF, 0, 0);
    // Stalled converters: two words fill the buffer, nothing is lost.
    sink_mode <= 2'h2;
    repeat (2) @(posedge ref_clk);
    send(2'h2, 24'h123456, 26'sh0123456, 26'sh07FFFFF);
    send(2'h1, 24'h123456, 26'sh0, 26'sh07FFFFF);
    s_valid <= 1'b0;
    @(negedge ref_clk);
    chk({31'h0, s_ready}, 32'h0, "buffer full");
    @(posedge ref_clk);
    sink_mode <= 2'h0;
    idle_drain();
    @(negedge ref_clk);
    chk({31'h0, dac_valid}, 32'h0, "buffer empty");
    @(posedge ref_clk);
    // Random traffic back to back against random stalls.
    sink_mode <= 2'h1;
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      c = (r[25:24] == 2'h3) ? 2'h2 : r[25:24];
      g = (c == 2'h0) ? {r[23], r[23:0], 1'b0} :
          (c == 2'h1) ? 26'sh0 : {{2{r[23]}}, r[23:0]};
      send(c, r[23:0], g, 26'sh07FFFFF);
    end
    idle_drain();
    chk(32'(expq.size()), 32'h0, "words outstanding");
    complete_run();
  end
endmodule
